// *** acb_pkg.sv ***
// package: bus field layouts, tag groups, register map and parity helpers
package acb_pkg;

  typedef struct packed {
    logic [0:7] bits;
    logic par;
  } acb_byte_t;

  typedef struct packed {
    acb_byte_t b0;
    acb_byte_t b1;
  } acb_half_t;

  typedef struct packed {
    logic io;
    logic addr_tag;
    logic data_tag;
    logic grant_scanner;
    logic grant_channel;
    logic halt;
    logic out_dir;
  } acb_tags_t;

  typedef struct packed {
    logic withdrawn;
    logic req_scanner;
    logic req_channel;
    logic byte_valid;
    logic half_valid;
    logic chain_end;
    logic modifier;
    logic par_req;
    logic ipl;
  } acb_resp_t;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_OPEN = 10'h002,
    S_ADDR = 10'h004,
    S_GAP = 10'h008,
    S_DATA = 10'h010,
    S_HALT = 10'h020,
    S_CLOSE = 10'h040,
    S_DONE = 10'h080,
    S_POLL = 10'h100,
    S_REST = 10'h200
  } acb_state_t;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PIO_CMD = 8'h04;
  localparam logic [7:0] OFF_PIO_WDATA = 8'h08;
  localparam logic [7:0] OFF_PIO_RDATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_REQ = 8'h14;
  localparam logic [7:0] OFF_CSCW = 8'h18;
  localparam logic [7:0] OFF_STEAL_DATA = 8'h1C;

  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_STEAL_EN = 2;
  localparam int CTRL_POLL_EN = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_HALTED = 2;
  localparam int ST_PAR_FIX = 3;
  localparam int ST_IPL = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;

  // interrupt request positions on the idle data bus
  localparam int INT_B0_LA_L2 = 1;
  localparam int INT_B0_CA_L1 = 5;
  localparam int INT_B1_CA_L3 = 0;
  localparam int INT_B1_LA_L1 = 5;

  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [7:0] CNT_RST = 8'h00;

  function automatic logic odd_par(input logic [0:7] b);
    return ~^b;
  endfunction : odd_par

  function automatic logic byte_bad(input acb_byte_t b);
    return ~^{b.bits, b.par};
  endfunction : byte_bad

  function automatic acb_half_t mk_half(input logic [15:0] d);
    acb_half_t h;
    h.b0.bits = d[15:8];
    h.b0.par = odd_par(d[15:8]);
    h.b1.bits = d[7:0];
    h.b1.par = odd_par(d[7:0]);
    return h;
  endfunction : mk_half

endpackage : acb_pkg

// *** acb_sync.sv ***
// two-flop synchroniser for bus lines arriving from the adapters
`timescale 1ns/10ps
`default_nettype none
module acb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : acb_sync
`default_nettype wire

// *** acb_ccu_bus.sv ***
// controller end of the adapter i/o bus: tag sequencing, parity, interrupt polling
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - operation tag rises before any other tag except the idle poll data tag, and falls after all others but error halt
// - error halt rises after address tag or grant falls, drops with operation tag
// - direction tag high for outbound transfers, low for inbound ones
// - during an operation the adapter acknowledges each control tag with halfword-valid, chain end or byte-valid plus modifier; controller then drops it
// - halfword-valid held while idle; controller waits for its release
// - bad inbound parity with parity check request raises error halt
// - bad parity without check request is corrected, stored and flagged
// - host initial-load detect raises level 1 interrupt toward maintenance
// - eighteen-line data bus, two odd-parity bytes, used during operations and for idle interrupt polling
// - idle interrupt bits sampled only after the data tag is raised
// - address tag marks adapter address on byte zero, command on byte one
// - data tag marks write data, read readiness, or idle request change window
// - interrupts sampled only after the shared request-withdrawn line is released
// - grant held until the adapter acknowledges, then dropped
module acb_ccu_bus (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output acb_pkg::acb_tags_t bus_tags,
  output acb_pkg::acb_half_t db_out,
  output logic db_oe,
  input wire acb_pkg::acb_half_t db_in,
  input wire acb_pkg::acb_resp_t resp_in,
  output logic maint_level1_irq
);

  acb_pkg::acb_half_t db_s;
  acb_pkg::acb_resp_t rs_s;
  logic [17:0] db_raw;
  logic [8:0] rs_raw;

  acb_pkg::acb_state_t state_ff;
  acb_pkg::acb_tags_t tags_ff;
  acb_pkg::acb_half_t db_out_ff;
  logic db_oe_ff;
  logic steal_ff;
  logic last_ff;
  logic [3:0] ctrl_ff;
  logic [15:0] cmd_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [4:0] status_ff;
  logic [4:0] nxt_status;
  logic [3:0] int_req_ff;
  logic [15:0] cscw_ff;
  logic [15:0] steal_data_ff;
  logic [7:0] steal_cnt_ff;
  logic ipl_d_ff;
  logic [31:0] reg_rdata_ff;

  logic ack;
  logic quiet;
  logic cap;
  logic bad;
  logic perr;
  logic pfix;
  logic accept_pio;
  logic accept_scn;
  logic accept_chn;
  logic poll_sample;
  logic [15:0] cap_data;

  // adapter lines come from another board, so they are synchronised first
  acb_sync #(.W(18)) u_sync_db (
    .clk(clk),
    .rst_b(rst_b),
    .d(db_in),
    .q(db_raw)
  );

  acb_sync #(.W(9)) u_sync_resp (
    .clk(clk),
    .rst_b(rst_b),
    .d(resp_in),
    .q(rs_raw)
  );

  assign db_s = db_raw;
  assign rs_s = rs_raw;

  assign ack = rs_s.half_valid | rs_s.chain_end | (rs_s.byte_valid & rs_s.modifier);
  assign quiet = !rs_s.half_valid && !rs_s.chain_end && !rs_s.byte_valid;
  assign cap = ack && ((state_ff == acb_pkg::S_ADDR && steal_ff) ||
                       (state_ff == acb_pkg::S_DATA && (steal_ff || !ctrl_ff[acb_pkg::CTRL_WRITE])));
  // a lone byte only has byte one meaningful, so byte zero parity is ignored
  assign bad = rs_s.byte_valid ? acb_pkg::byte_bad(db_s.b1) :
               (acb_pkg::byte_bad(db_s.b0) | acb_pkg::byte_bad(db_s.b1));
  assign perr = cap && bad && rs_s.par_req;
  assign pfix = cap && bad && !rs_s.par_req;
  assign cap_data = rs_s.byte_valid ? {8'h00, db_s.b1.bits} : {db_s.b0.bits, db_s.b1.bits};

  assign accept_pio = state_ff == acb_pkg::S_IDLE && ctrl_ff[acb_pkg::CTRL_START];
  assign accept_scn = state_ff == acb_pkg::S_IDLE && !accept_pio &&
                      ctrl_ff[acb_pkg::CTRL_STEAL_EN] && rs_s.req_scanner;
  assign accept_chn = state_ff == acb_pkg::S_IDLE && !accept_pio && !accept_scn &&
                      ctrl_ff[acb_pkg::CTRL_STEAL_EN] && rs_s.req_channel;
  assign poll_sample = state_ff == acb_pkg::S_POLL && !rs_s.withdrawn;

  // bus sequencing: tags, direction, data drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= acb_pkg::S_IDLE;
      tags_ff <= '0;
      db_out_ff <= '0;
      db_oe_ff <= 1'b0;
      steal_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        acb_pkg::S_IDLE: begin
          if (accept_pio || accept_scn || accept_chn) begin
            tags_ff.io <= 1'b1;
            steal_ff <= !accept_pio;
            state_ff <= acb_pkg::S_OPEN;
          end else if (ctrl_ff[acb_pkg::CTRL_POLL_EN]) begin
            tags_ff.data_tag <= 1'b1;
            state_ff <= acb_pkg::S_POLL;
          end
        end
        acb_pkg::S_OPEN: begin
          // adapters hold halfword-valid until they see the operation tag
          if (quiet) begin
            if (steal_ff) begin
              tags_ff.grant_scanner <= rs_s.req_scanner;
              tags_ff.grant_channel <= !rs_s.req_scanner;
              tags_ff.out_dir <= 1'b0;
            end else begin
              tags_ff.addr_tag <= 1'b1;
              tags_ff.out_dir <= 1'b1;
              db_out_ff <= acb_pkg::mk_half(cmd_ff);
              db_oe_ff <= 1'b1;
            end
            state_ff <= acb_pkg::S_ADDR;
          end
        end
        acb_pkg::S_ADDR: begin
          if (ack) begin
            tags_ff.addr_tag <= 1'b0;
            tags_ff.grant_scanner <= 1'b0;
            tags_ff.grant_channel <= 1'b0;
            db_oe_ff <= 1'b0;
            last_ff <= 1'b0;
            state_ff <= perr ? acb_pkg::S_HALT : acb_pkg::S_GAP;
          end
        end
        acb_pkg::S_GAP: begin
          if (quiet) begin
            if (last_ff) begin
              state_ff <= acb_pkg::S_CLOSE;
            end else begin
              tags_ff.data_tag <= 1'b1;
              tags_ff.out_dir <= !steal_ff && ctrl_ff[acb_pkg::CTRL_WRITE];
              db_out_ff <= acb_pkg::mk_half(wdata_ff);
              db_oe_ff <= !steal_ff && ctrl_ff[acb_pkg::CTRL_WRITE];
              state_ff <= acb_pkg::S_DATA;
            end
          end
        end
        acb_pkg::S_DATA: begin
          if (ack) begin
            tags_ff.data_tag <= 1'b0;
            db_oe_ff <= 1'b0;
            last_ff <= !steal_ff || rs_s.chain_end || (rs_s.byte_valid && rs_s.modifier);
            state_ff <= perr ? acb_pkg::S_HALT : acb_pkg::S_GAP;
          end
        end
        acb_pkg::S_HALT: begin
          tags_ff.halt <= 1'b1;
          state_ff <= acb_pkg::S_CLOSE;
        end
        acb_pkg::S_CLOSE: begin
          tags_ff.out_dir <= 1'b0;
          state_ff <= acb_pkg::S_DONE;
        end
        acb_pkg::S_DONE: begin
          tags_ff.io <= 1'b0;
          tags_ff.halt <= 1'b0;
          state_ff <= acb_pkg::S_IDLE;
        end
        acb_pkg::S_POLL: begin
          if (poll_sample) begin
            tags_ff.data_tag <= 1'b0;
            state_ff <= acb_pkg::S_REST;
          end
        end
        acb_pkg::S_REST: begin
          // one idle cycle so adapters see the data tag fall before the next window
          state_ff <= acb_pkg::S_IDLE;
        end
      endcase
    end
  end

  // software-written control and command registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= acb_pkg::CTRL_RST;
      cmd_ff <= acb_pkg::HALF_RST;
      wdata_ff <= acb_pkg::HALF_RST;
    end else begin
      if (reg_wr && reg_addr == acb_pkg::OFF_CTRL) begin
        ctrl_ff <= reg_wdata[3:0];
      end else if (accept_pio) begin
        ctrl_ff[acb_pkg::CTRL_START] <= 1'b0;
      end
      if (reg_wr && reg_addr == acb_pkg::OFF_PIO_CMD) begin
        cmd_ff <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == acb_pkg::OFF_PIO_WDATA) begin
        wdata_ff <= reg_wdata[15:0];
      end
    end
  end

  // inbound data capture; corrected parity is implicit since only data bits are kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= acb_pkg::HALF_RST;
      cscw_ff <= acb_pkg::HALF_RST;
      steal_data_ff <= acb_pkg::HALF_RST;
      steal_cnt_ff <= acb_pkg::CNT_RST;
    end else begin
      if (accept_scn || accept_chn) begin
        steal_cnt_ff <= acb_pkg::CNT_RST;
      end
      if (cap && !perr) begin
        if (state_ff == acb_pkg::S_ADDR) begin
          cscw_ff <= cap_data;
        end else if (steal_ff) begin
          steal_data_ff <= cap_data;
          steal_cnt_ff <= steal_cnt_ff + (rs_s.byte_valid ? 8'h01 : 8'h02);
        end else begin
          rdata_ff <= cap_data;
        end
      end
    end
  end

  // idle interrupt bits are only trusted once every adapter released withdrawn
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_req_ff <= 4'h0;
    end else if (poll_sample) begin
      int_req_ff <= {db_s.b0.bits[acb_pkg::INT_B0_LA_L2], db_s.b0.bits[acb_pkg::INT_B0_CA_L1],
                     db_s.b1.bits[acb_pkg::INT_B1_CA_L3], db_s.b1.bits[acb_pkg::INT_B1_LA_L1]};
    end
  end

  // sticky status bits other than busy, write one to clear; a set in the same cycle wins
  always_comb begin
    nxt_status = status_ff;
    if (reg_wr && reg_addr == acb_pkg::OFF_STATUS) begin
      nxt_status = status_ff & ~reg_wdata[4:0];
    end
    nxt_status[acb_pkg::ST_BUSY] = state_ff != acb_pkg::S_IDLE && state_ff != acb_pkg::S_POLL &&
                                   state_ff != acb_pkg::S_REST;
    if (state_ff == acb_pkg::S_DONE) begin
      nxt_status[acb_pkg::ST_DONE] = 1'b1;
    end
    if (state_ff == acb_pkg::S_HALT) begin
      nxt_status[acb_pkg::ST_HALTED] = 1'b1;
    end
    if (pfix) begin
      nxt_status[acb_pkg::ST_PAR_FIX] = 1'b1;
    end
    if (rs_s.ipl && !ipl_d_ff) begin
      nxt_status[acb_pkg::ST_IPL] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_ff <= acb_pkg::STATUS_RST;
      ipl_d_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      ipl_d_ff <= rs_s.ipl;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        acb_pkg::OFF_CTRL: reg_rdata_ff <= {28'h000_0000, ctrl_ff};
        acb_pkg::OFF_PIO_CMD: reg_rdata_ff <= {16'h0000, cmd_ff};
        acb_pkg::OFF_PIO_WDATA: reg_rdata_ff <= {16'h0000, wdata_ff};
        acb_pkg::OFF_PIO_RDATA: reg_rdata_ff <= {16'h0000, rdata_ff};
        acb_pkg::OFF_STATUS: reg_rdata_ff <= {27'h000_0000, status_ff};
        acb_pkg::OFF_INT_REQ: reg_rdata_ff <= {28'h000_0000, int_req_ff};
        acb_pkg::OFF_CSCW: reg_rdata_ff <= {16'h0000, cscw_ff};
        acb_pkg::OFF_STEAL_DATA: reg_rdata_ff <= {8'h00, steal_cnt_ff, steal_data_ff};
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign bus_tags = tags_ff;
  assign db_out = db_out_ff;
  assign db_oe = db_oe_ff;
  assign maint_level1_irq = status_ff[acb_pkg::ST_IPL];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_io_first: assert property ($rose(tags_ff.addr_tag | tags_ff.data_tag & tags_ff.io) |-> $past(tags_ff.io))
    else $error("control tag rose without operation tag");
  a_io_last: assert property ($fell(tags_ff.io) |-> $past(!tags_ff.addr_tag && !tags_ff.data_tag &&
    !tags_ff.grant_scanner && !tags_ff.grant_channel && !tags_ff.out_dir))
    else $error("operation tag fell before other tags");
  a_halt_after_tag: assert property ($rose(tags_ff.halt) |-> $past(!tags_ff.addr_tag &&
    !tags_ff.grant_scanner && !tags_ff.grant_channel) && tags_ff.io)
    else $error("halt raised while address tag or grant active");
  a_halt_with_io: assert property (tags_ff.halt |-> ##[1:2] ($fell(tags_ff.io) && !tags_ff.halt))
    else $error("halt not dropped together with operation tag");
  a_dir_follows: assert property (tags_ff.data_tag && tags_ff.io |-> tags_ff.out_dir == db_oe_ff)
    else $error("direction tag disagrees with data drive");
  a_drive_in_op: assert property (db_oe_ff |-> tags_ff.io && tags_ff.out_dir)
    else $error("data bus driven outside an outbound operation");
  a_parity_halt: assert property (perr |-> ##2 tags_ff.halt)
    else $error("checked parity error did not halt");
  a_parity_fix: assert property (pfix |=> status_ff[acb_pkg::ST_PAR_FIX] && !tags_ff.halt)
    else $error("unchecked parity error not flagged");
  a_ipl_level1: assert property ($rose(rs_s.ipl) |=> maint_level1_irq)
    else $error("initial-load detect did not raise level 1");
  a_poll_window: assert property (int_req_ff != $past(int_req_ff) |-> $past(tags_ff.data_tag &&
    !tags_ff.io && !rs_s.withdrawn))
    else $error("interrupt bits sampled outside idle data tag window");
  a_addr_payload: assert property ($rose(tags_ff.addr_tag) |-> db_oe_ff &&
    db_out_ff.b0.bits == cmd_ff[15:8] && db_out_ff.b1.bits == cmd_ff[7:0])
    else $error("address tag without address and command on bus");
  a_wait_release: assert property ($rose(tags_ff.addr_tag | tags_ff.grant_scanner | tags_ff.grant_channel)
    |-> $past(quiet))
    else $error("control tag raised while halfword-valid still held");
  a_grant_drop: assert property ((tags_ff.grant_scanner || tags_ff.grant_channel) && ack |=>
    !tags_ff.grant_scanner && !tags_ff.grant_channel)
    else $error("grant held after acknowledge");

  c_pio_write: cover property (state_ff == acb_pkg::S_DATA && ctrl_ff[acb_pkg::CTRL_WRITE] && ack && !steal_ff);
  c_pio_read: cover property (cap && !steal_ff);
  c_steal_end: cover property (state_ff == acb_pkg::S_DATA && steal_ff && rs_s.chain_end);
  c_poll: cover property (poll_sample);
  c_halt: cover property ($rose(tags_ff.halt));

endmodule : acb_ccu_bus
`default_nettype wire

// *** acb_adapter_model.sv ***
// partner model: the adapters that answer the controller on the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module acb_adapter_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire acb_pkg::acb_tags_t tags,
  input wire acb_pkg::acb_half_t db_out,
  output acb_pkg::acb_half_t db_in,
  output acb_pkg::acb_resp_t resp,
  input wire logic [1:0] want_steal,
  input wire logic [3:0] n_words,
  input wire logic byte_end,
  input wire logic bad_par,
  input wire logic par_req,
  input wire logic ipl,
  input wire logic [3:0] ints,
  input wire logic [3:0] lag,
  input wire logic [15:0] base,
  output logic [15:0] got_cmd,
  output logic [15:0] got_wdata,
  output logic [1:0] got_grant,
  output logic check_ff
);
  logic ctl;
  logic acked_ff;
  logic last_ff;
  logic data_ff;
  logic granted_ff;
  logic toggle_ff;
  logic [3:0] wait_ff;
  logic [3:0] cnt_ff;
  logic [15:0] word;
  function automatic acb_pkg::acb_half_t pk(input logic [15:0] d);
    acb_pkg::acb_half_t h;
    h.b0.bits = d[15:8];
    h.b0.par = ~^d[15:8];
    h.b1.bits = d[7:0];
    h.b1.par = ~^d[7:0];
    return h;
  endfunction : pk
  assign ctl = tags.addr_tag | tags.data_tag | tags.grant_scanner | tags.grant_channel;
  assign word = tags.data_tag ? base + 16'(cnt_ff) : base;
  // ack after a programmable lag so slow adapters are exercised too
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acked_ff <= 1'b0;
      last_ff <= 1'b0;
      data_ff <= 1'b0;
      wait_ff <= 4'h0;
      cnt_ff <= 4'h0;
      got_cmd <= 16'h0000;
      got_wdata <= 16'h0000;
      got_grant <= 2'b00;
    end else if (!tags.io) begin
      acked_ff <= 1'b0;
      last_ff <= 1'b0;
      wait_ff <= 4'h0;
      cnt_ff <= 4'h0;
    end else if (ctl && !acked_ff) begin
      if (wait_ff == lag) begin
        acked_ff <= 1'b1;
        data_ff <= tags.data_tag;
        last_ff <= granted_ff && tags.data_tag && (cnt_ff == n_words - 4'h1);
        if (tags.addr_tag) got_cmd <= {db_out.b0.bits, db_out.b1.bits};
        if (tags.data_tag && tags.out_dir) got_wdata <= {db_out.b0.bits, db_out.b1.bits};
        if (tags.grant_scanner || tags.grant_channel) got_grant <= {tags.grant_scanner, tags.grant_channel};
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else if (!ctl && acked_ff) begin
      acked_ff <= 1'b0;
      last_ff <= 1'b0;
      wait_ff <= 4'h0;
      cnt_ff <= cnt_ff + {3'b000, data_ff};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      granted_ff <= 1'b0;
      check_ff <= 1'b0;
      toggle_ff <= 1'b0;
    end else begin
      toggle_ff <= ~toggle_ff;
      if (want_steal == 2'b00) granted_ff <= 1'b0;
      else if (tags.grant_scanner || tags.grant_channel) granted_ff <= 1'b1;
      if (tags.halt) check_ff <= 1'b1;
    end
  end
  assign resp.withdrawn = tags.io;
  assign resp.req_scanner = want_steal[1] & ~granted_ff;
  assign resp.req_channel = want_steal[0] & ~granted_ff;
  assign resp.half_valid = ~tags.io | (acked_ff & ~last_ff);
  assign resp.chain_end = acked_ff & last_ff & ~byte_end;
  assign resp.byte_valid = acked_ff & last_ff & byte_end;
  assign resp.modifier = acked_ff & last_ff & byte_end;
  assign resp.par_req = par_req;
  assign resp.ipl = ipl;
  // released bus shows a changing pattern, never the last value
  always_comb begin
    if (!tags.io) begin
      db_in = pk({1'b0, ints[3], 3'b000, ints[2], 2'b00, ints[1], 4'h0, ints[0], 2'b00});
    end else if (ctl && !tags.out_dir) begin
      db_in = pk(word);
      if (bad_par && tags.data_tag && cnt_ff == 4'h0) db_in.b1.par = ~db_in.b1.par;
    end else begin
      db_in = {18{toggle_ff}} ^ 18'h2_AAAA;
    end
  end
endmodule : acb_adapter_model
`default_nettype wire

// *** acb_ccu_bus_tb.sv ***
// testbench: register-driven transfers against the adapter model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module acb_ccu_bus_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  acb_pkg::acb_tags_t bus_tags;
  acb_pkg::acb_half_t db_out;
  logic db_oe;
  acb_pkg::acb_half_t db_in;
  acb_pkg::acb_resp_t resp_in;
  logic irq;
  logic [1:0] want_steal = 2'b00;
  logic [3:0] n_words = 4'h1;
  logic byte_end = 1'b0;
  logic bad_par = 1'b0;
  logic par_req = 1'b0;
  logic ipl = 1'b0;
  logic [3:0] ints = 4'h0;
  logic [3:0] lag = 4'h0;
  logic [15:0] base = 16'h0000;
  logic [15:0] got_cmd;
  logic [15:0] got_wdata;
  logic [1:0] got_grant;
  logic check_bit;
  logic halt_q = 1'b0;
  logic [31:0] s;
  int miscompares = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  acb_ccu_bus u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_tags(bus_tags), .db_out(db_out), .db_oe(db_oe),
    .db_in(db_in), .resp_in(resp_in), .maint_level1_irq(irq));
  acb_adapter_model u_adp (.clk(clk), .rst_b(rst_b), .tags(bus_tags), .db_out(db_out), .db_in(db_in),
    .resp(resp_in), .want_steal(want_steal), .n_words(n_words), .byte_end(byte_end), .bad_par(bad_par),
    .par_req(par_req), .ipl(ipl), .ints(ints), .lag(lag), .base(base), .got_cmd(got_cmd),
    .got_wdata(got_wdata), .got_grant(got_grant), .check_ff(check_bit));
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // a spare edge after each strobe keeps drivers to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : chkrd
  task automatic wait_done(output logic [31:0] st);
    st = 32'h0000_0000;
    for (int k = 0; k < 200; k++) begin
      rd(acb_pkg::OFF_STATUS, st);
      if (st[acb_pkg::ST_DONE] === 1'b1 || st[acb_pkg::ST_HALTED] === 1'b1) break;
    end
    // busy trails the state by a cycle, so read once more after done shows
    rd(acb_pkg::OFF_STATUS, st);
  endtask : wait_done
  always @(posedge clk) begin
    if (rst_b) begin
      `CHK(~bus_tags.io & (|{bus_tags[5], bus_tags[3:0]}), 1'b0)
      `CHK(bus_tags.halt & (bus_tags.addr_tag | bus_tags.grant_scanner | bus_tags.grant_channel), 1'b0)
      `CHK(db_oe & ~(bus_tags.io & bus_tags.out_dir), 1'b0)
      if (db_oe) `CHK({^db_out.b0, ^db_out.b1}, 2'b11)
      if (halt_q & ~bus_tags.halt) `CHK(bus_tags.io, 1'b0)
    end
    halt_q <= bus_tags.halt;
  end
  initial begin
    #300_000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    `CHK({bus_tags, db_oe, irq}, 9'h000)
    rst_b <= 1'b1;
    @(posedge clk);
    chkrd(acb_pkg::OFF_STATUS, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    chkrd(8'h20, 32'h0000_0000);
    lag <= 4'h2;
    wr(acb_pkg::OFF_PIO_CMD, 32'h0000_4A21);
    wr(acb_pkg::OFF_PIO_WDATA, 32'h0000_C3F0);
    wr(acb_pkg::OFF_CTRL, 32'h0000_0003);
    wait_done(s);
    `CHK(s[4:0], 5'h02)
    `CHK(got_cmd, 16'h4A21)
    `CHK(got_wdata, 16'hC3F0)
    wr(acb_pkg::OFF_STATUS, 32'h0000_001E);
    chkrd(acb_pkg::OFF_STATUS, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      base <= 16'h1234 + 16'(i);
      bad_par <= 1'b1;
      par_req <= i[0];
      wr(acb_pkg::OFF_CTRL, 32'h0000_0001);
      wait_done(s);
      if (i == 0) begin
        `CHK(s[3:1], 3'b101)
        chkrd(acb_pkg::OFF_PIO_RDATA, 32'h0000_1234);
      end else begin
        `CHK({s[acb_pkg::ST_HALTED], check_bit}, 2'b11)
      end
      wr(acb_pkg::OFF_STATUS, 32'h0000_001E);
    end
    bad_par <= 1'b0;
    par_req <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      want_steal <= (i == 0) ? 2'b10 : 2'b01;
      n_words <= (i == 0) ? 4'h3 : 4'h2;
      byte_end <= i[0];
      lag <= (i == 0) ? 4'h0 : 4'h3;
      base <= (i == 0) ? 16'hA000 : 16'h5A00;
      wr(acb_pkg::OFF_CTRL, 32'h0000_0004);
      wait_done(s);
      `CHK(s[acb_pkg::ST_DONE], 1'b1)
      rd(acb_pkg::OFF_STEAL_DATA, s);
      if (i == 0) `CHK(s & 32'h00FF_FFFF, 32'h0006_A002)
      else `CHK(s & 32'h00FF_00FF, 32'h0003_0001)
      `CHK(got_grant, (i == 0) ? 2'b10 : 2'b01)
      want_steal <= 2'b00;
      wr(acb_pkg::OFF_CTRL, 32'h0000_0000);
      wr(acb_pkg::OFF_STATUS, 32'h0000_001E);
    end
    wr(acb_pkg::OFF_CTRL, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      ints <= 4'(1 << i);
      repeat (30) @(posedge clk);
      chkrd(acb_pkg::OFF_INT_REQ, 32'(1 << i));
      `CHK(irq, 1'b0)
    end
    ints <= 4'h0;
    wr(acb_pkg::OFF_CTRL, 32'h0000_0000);
    ipl <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(acb_pkg::OFF_STATUS, s);
    `CHK(s[acb_pkg::ST_IPL], 1'b1)
    ipl <= 1'b0;
    repeat (4) @(posedge clk);
    wr(acb_pkg::OFF_STATUS, 32'h0000_0010);
    @(posedge clk);
    `CHK(irq, 1'b0)
    // bus reset in mid-operation: everything back to idle and ready
    wr(acb_pkg::OFF_CTRL, 32'h0000_0003);
    repeat (5) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({bus_tags, db_oe, resp_in.half_valid, check_bit}, 10'h002)
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    wr(acb_pkg::OFF_CTRL, 32'h0000_0003);
    wait_done(s);
    `CHK(s[4:0], 5'h02)
    conclude();
  end
endmodule : acb_ccu_bus_tb
`default_nettype wire
